// *** hdl/mpfs_consts.svh ***
// constants for the motor position feedback setup block
`ifndef MPFS_CONSTS_SVH
`define MPFS_CONSTS_SVH
// register offsets (word index; byte address is four times this)
`define MPFS_IDX_PPR 16'h304B
`define MPFS_IDX_OPT 16'h306C
`define MPFS_IDX_SEL 16'h382E
`define MPFS_IDX_MOTOR 16'h3900
`define MPFS_IDX_STATUS 16'h3901
`define MPFS_IDX_MASK 16'h3902
`define MPFS_IDX_FAULT 16'h3903
`define MPFS_IDX_POS 16'h3904
`define MPFS_IDX_SPEED 16'h3905
// field values
`define MPFS_SEL_QUAD 16'h0001
`define MPFS_SEL_SINCOS 16'h0002
`define MPFS_MOTOR_IND 16'h0000
`define MPFS_MOTOR_SPM 16'h0001
`define MPFS_OPT_INV_BIT 0
`define MPFS_PPR_MIN 16'h0020
`define MPFS_PPR_MAX 16'h0100
`define MPFS_FAULT_PCF 8'h31
// reset values
`define MPFS_PPR_RST 16'h0020
`define MPFS_OPT_RST 16'h0000
`define MPFS_SEL_RST 16'h0001
`define MPFS_MOTOR_RST 16'h0000
// status bits
`define MPFS_ST_MISMATCH 0
`define MPFS_ST_PCF 1
`define MPFS_ST_BADSEL 2
// speed sample interval: 1 ms at 20 MHz
`define MPFS_SAMPLE_US 1000
`define MPFS_CLK_MHZ 20
`define MPFS_SAMPLE_CYC (`MPFS_SAMPLE_US * `MPFS_CLK_MHZ)
`endif

// *** hdl/mpfs_pkg.sv ***
// types for the motor position feedback setup block
package mpfs_pkg;
	typedef enum logic [1:0] {
		MPFS_SENS_NONE,
		MPFS_SENS_QUAD,
		MPFS_SENS_SINCOS
	} mpfs_sens_t;
endpackage

// *** hdl/mpfs_quad_dec.sv ***
// quadrature decoder with selectable direction inversion
`timescale 1ns/1ps
module mpfs_quad_dec
	import mpfs_pkg::*;
#(
	parameter int CNT_W = 16
)
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic enc_a_i,
	input wire logic enc_b_i,
	input wire logic invert_i,
	output logic step_o,
	output logic dir_up_o
);
	typedef struct packed {
		logic a;
		logic b;
		logic step;
		logic up;
	} mpfs_qd_t;
	mpfs_qd_t st_r, st_nxt;
	always_comb
	begin
		logic raw_up;
		raw_up = 1'b0;
		st_nxt = st_r;
		st_nxt.a = enc_a_i;
		st_nxt.b = enc_b_i;
		st_nxt.step = (enc_a_i ^ st_r.a) ^ (enc_b_i ^ st_r.b);
		raw_up = st_r.a ^ enc_b_i;
		// inversion flips the decoded sense before counting
		st_nxt.up = raw_up ^ invert_i;
	end
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			// load the pins so a phase left over from before reset is no edge
			st_r <= '0;
			st_r.a <= enc_a_i;
			st_r.b <= enc_b_i;
		end
		else
			st_r <= st_nxt;
	end
	assign step_o = st_r.step;
	assign dir_up_o = st_r.up;
endmodule

// *** hdl/mpfs_speed.sv ***
// signed speed estimate from count delta per sample interval
`timescale 1ns/1ps
`include "mpfs_consts.svh"
module mpfs_speed
	import mpfs_pkg::*;
#(
	parameter int SAMPLE_CYC = `MPFS_SAMPLE_CYC
)
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [15:0] count_i,
	input wire logic [15:0] ppr_i,
	output logic [15:0] speed_o
);
	typedef struct packed {
		logic [31:0] tick;
		logic [15:0] last;
		logic [15:0] speed;
	} mpfs_sp_t;
	mpfs_sp_t st_r, st_nxt;
	always_comb
	begin
		logic signed [15:0] delta;
		logic signed [31:0] scaled;
		delta = '0;
		scaled = '0;
		st_nxt = st_r;
		if (st_r.tick >= 32'(SAMPLE_CYC - 1))
		begin
			st_nxt.tick = '0;
			delta = $signed(count_i - st_r.last);
			// counts per interval times 256 over pulses per rev
			scaled = ($signed({{16{delta[15]}}, delta}) <<< 8)
				/ $signed({16'h0000, ppr_i});
			st_nxt.speed = scaled[15:0];
			st_nxt.last = count_i;
		end
		else
			st_nxt.tick = st_r.tick + 32'h00000001;
	end
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	assign speed_o = st_r.speed;
endmodule

// *** hdl/mpfs_top.sv ***
// motor position feedback setup: configuration, checks, position and speed
`timescale 1ns/1ps
`include "mpfs_consts.svh"
module mpfs_top
	import mpfs_pkg::*;
#(
	parameter int SAMPLE_CYC = `MPFS_SAMPLE_CYC
)
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic enc_a_i,
	input wire logic enc_b_i,
	output logic [15:0] rdata_o,
	output logic irq_o,
	output logic mismatch_o,
	output logic power_cycle_required_marker_o,
	output logic [7:0] fault_code_o,
	output logic [15:0] position_o,
	output logic [15:0] speed_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] ppr;
		logic [15:0] opt;
		logic [15:0] sel;
		logic [15:0] motor;
		logic [2:0] status;
		logic [2:0] mask;
		logic power_cycle_required_marker;
		logic [7:0] fault;
		logic mismatch;
		logic irq;
		logic [15:0] count;
		logic [15:0] pos;
		logic [15:0] speed;
		logic [15:0] rdata;
	} mpfs_st_t;
	mpfs_st_t st_r, st_nxt;
	logic step;
	logic dir_up;
	logic [15:0] speed_w;
	mpfs_sens_t sens;
	// ----------------------------------------
	// decoder and speed estimator
	// ----------------------------------------
	mpfs_quad_dec #(
		.CNT_W(16)
	) u_dec (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.enc_a_i(enc_a_i),
		.enc_b_i(enc_b_i),
		.invert_i(st_r.opt[`MPFS_OPT_INV_BIT]),
		.step_o(step),
		.dir_up_o(dir_up)
	);
	mpfs_speed #(
		.SAMPLE_CYC(SAMPLE_CYC)
	) u_spd (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.count_i(st_r.count),
		.ppr_i(st_r.ppr),
		.speed_o(speed_w)
	);
	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		logic [2:0] ev;
		logic [15:0] lim;
		ev = '0;
		lim = '0;
		st_nxt = st_r;
		sens = MPFS_SENS_NONE;
		if (st_r.sel == `MPFS_SEL_QUAD)
			sens = MPFS_SENS_QUAD;
		else if (st_r.sel == `MPFS_SEL_SINCOS)
			sens = MPFS_SENS_SINCOS;
		// register writes
		if (wr_i)
		begin
			case (addr_i)
			`MPFS_IDX_PPR:
			begin
				// out-of-range counts are clamped to the legal span
				lim = wdata_i;
				if (lim < `MPFS_PPR_MIN)
					lim = `MPFS_PPR_MIN;
				else if (lim > `MPFS_PPR_MAX)
					lim = `MPFS_PPR_MAX;
				st_nxt.ppr = lim;
				if (lim != st_r.ppr)
					ev[`MPFS_ST_PCF] = 1'b1;
			end
			`MPFS_IDX_OPT:
			begin
				st_nxt.opt = wdata_i;
				if (wdata_i[`MPFS_OPT_INV_BIT] != st_r.opt[`MPFS_OPT_INV_BIT])
					ev[`MPFS_ST_PCF] = 1'b1;
			end
			`MPFS_IDX_SEL:
			begin
				st_nxt.sel = wdata_i;
				if (wdata_i != `MPFS_SEL_QUAD && wdata_i != `MPFS_SEL_SINCOS)
					ev[`MPFS_ST_BADSEL] = 1'b1;
			end
			`MPFS_IDX_MOTOR:
				st_nxt.motor = wdata_i;
			`MPFS_IDX_MASK:
				st_nxt.mask = wdata_i[2:0];
			default:
				st_nxt.motor = st_nxt.motor;
			endcase
		end
		// mismatch check runs continuously
		st_nxt.mismatch = 1'b0;
		if (st_r.motor == `MPFS_MOTOR_IND && sens != MPFS_SENS_QUAD)
			st_nxt.mismatch = 1'b1;
		if (st_r.motor == `MPFS_MOTOR_SPM && sens != MPFS_SENS_SINCOS)
			st_nxt.mismatch = 1'b1;
		if (st_nxt.mismatch && !st_r.mismatch)
			ev[`MPFS_ST_MISMATCH] = 1'b1;
		// latched until reset, which stands for a power cycle
		if (ev[`MPFS_ST_PCF])
		begin
			st_nxt.power_cycle_required_marker = 1'b1;
			st_nxt.fault = `MPFS_FAULT_PCF;
		end
		// status: write one to clear, a new event wins
		if (wr_i && addr_i == `MPFS_IDX_STATUS)
			st_nxt.status = st_r.status & ~wdata_i[2:0];
		st_nxt.status = st_nxt.status | ev;
		st_nxt.irq = |(st_nxt.status & st_nxt.mask);
		// position within one revolution
		if (step && sens == MPFS_SENS_QUAD)
		begin
			if (dir_up)
			begin
				st_nxt.count = st_r.count + 16'h0001;
				if (st_r.pos >= st_r.ppr - 16'h0001)
					st_nxt.pos = 16'h0000;
				else
					st_nxt.pos = st_r.pos + 16'h0001;
			end
			else
			begin
				st_nxt.count = st_r.count - 16'h0001;
				if (st_r.pos == 16'h0000)
					st_nxt.pos = st_r.ppr - 16'h0001;
				else
					st_nxt.pos = st_r.pos - 16'h0001;
			end
		end
		// a smaller count written under the position restarts the revolution
		if (st_nxt.pos >= st_nxt.ppr)
			st_nxt.pos = 16'h0000;
		st_nxt.speed = speed_w;
		// read data stands one cycle after the strobe
		st_nxt.rdata = 16'h0000;
		if (rd_i)
		begin
			case (addr_i)
			`MPFS_IDX_PPR: st_nxt.rdata = st_r.ppr;
			`MPFS_IDX_OPT: st_nxt.rdata = st_r.opt;
			`MPFS_IDX_SEL: st_nxt.rdata = st_r.sel;
			`MPFS_IDX_MOTOR: st_nxt.rdata = st_r.motor;
			`MPFS_IDX_STATUS: st_nxt.rdata = {13'h0000, st_r.status};
			`MPFS_IDX_MASK: st_nxt.rdata = {13'h0000, st_r.mask};
			`MPFS_IDX_FAULT: st_nxt.rdata = {st_r.power_cycle_required_marker, 7'h00, st_r.fault};
			`MPFS_IDX_POS: st_nxt.rdata = st_r.pos;
			`MPFS_IDX_SPEED: st_nxt.rdata = st_r.speed;
			default: st_nxt.rdata = 16'h0000;
			endcase
		end
	end
	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			st_r <= '0;
			st_r.ppr <= `MPFS_PPR_RST;
			st_r.opt <= `MPFS_OPT_RST;
			st_r.sel <= `MPFS_SEL_RST;
			st_r.motor <= `MPFS_MOTOR_RST;
		end
		else
			st_r <= st_nxt;
	end
	assign rdata_o = st_r.rdata;
	assign irq_o = st_r.irq;
	assign mismatch_o = st_r.mismatch;
	assign power_cycle_required_marker_o = st_r.power_cycle_required_marker;
	assign fault_code_o = st_r.fault;
	assign position_o = st_r.pos;
	assign speed_o = st_r.speed;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_pcf_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		st_r.power_cycle_required_marker |=> st_r.power_cycle_required_marker && st_r.fault == `MPFS_FAULT_PCF)
		else $error("parameter change fault dropped");
	chk_opt_change: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_i && addr_i == `MPFS_IDX_OPT && wdata_i[0] != st_r.opt[0]) |=> st_r.power_cycle_required_marker)
		else $error("invert change did not latch fault");
	chk_ppr_change: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_i && addr_i == `MPFS_IDX_PPR && wdata_i != st_r.ppr
		&& wdata_i >= `MPFS_PPR_MIN && wdata_i <= `MPFS_PPR_MAX) |=> st_r.power_cycle_required_marker)
		else $error("pulse count change did not latch fault");
	chk_ind_match: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st_r.motor == `MPFS_MOTOR_IND && st_r.sel != `MPFS_SEL_QUAD) |=> st_r.mismatch)
		else $error("induction mismatch missed");
	chk_spm_match: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st_r.motor == `MPFS_MOTOR_SPM && st_r.sel != `MPFS_SEL_SINCOS) |=> st_r.mismatch)
		else $error("magnet motor mismatch missed");
	chk_bad_sel: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_i && addr_i == `MPFS_IDX_SEL && wdata_i != `MPFS_SEL_QUAD
		&& wdata_i != `MPFS_SEL_SINCOS) |=> st_r.status[`MPFS_ST_BADSEL])
		else $error("invalid selector not flagged");
	chk_ppr_range: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		st_r.ppr >= `MPFS_PPR_MIN && st_r.ppr <= `MPFS_PPR_MAX && st_r.pos < st_r.ppr)
		else $error("pulse count or position out of range");
	chk_pos_up: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(step && dir_up && sens == MPFS_SENS_QUAD && st_r.pos < st_r.ppr - 16'h0001)
		|=> st_r.pos == $past(st_r.pos) + 16'h0001)
		else $error("position did not advance");
	chk_irq_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		irq_o == |(st_r.status & st_r.mask))
		else $error("interrupt level wrong");
	// ----------------------------------------
	// checks: register bus
	// ----------------------------------------
	chk_rdata_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!rd_i
		|=> rdata_o == 16'h0000)
		else $error("read data without a read");
	chk_rd_ppr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(rd_i && addr_i == `MPFS_IDX_PPR)
		|=> rdata_o == $past(st_r.ppr))
		else $error("pulse count read back wrong");
	chk_rd_opt: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(rd_i && addr_i == `MPFS_IDX_OPT)
		|=> rdata_o == $past(st_r.opt))
		else $error("option flags read back wrong");
	chk_rd_sel: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(rd_i && addr_i == `MPFS_IDX_SEL)
		|=> rdata_o == $past(st_r.sel))
		else $error("sensor select read back wrong");
	chk_rd_fault: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(rd_i && addr_i == `MPFS_IDX_FAULT)
		|=> rdata_o == {$past(st_r.power_cycle_required_marker), 7'h00, $past(st_r.fault)})
		else $error("fault word read back wrong");
	chk_rd_status: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(rd_i && addr_i == `MPFS_IDX_STATUS)
		|=> rdata_o == {13'h0000, $past(st_r.status)})
		else $error("status read back wrong");
	chk_ppr_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_i && addr_i == `MPFS_IDX_PPR && wdata_i < `MPFS_PPR_MIN)
		|=> st_r.ppr == `MPFS_PPR_MIN)
		else $error("low pulse count not clamped");
	chk_ppr_high: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_i && addr_i == `MPFS_IDX_PPR && wdata_i > `MPFS_PPR_MAX)
		|=> st_r.ppr == `MPFS_PPR_MAX)
		else $error("high pulse count not clamped");
	chk_ppr_store: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_i && addr_i == `MPFS_IDX_PPR && wdata_i >= `MPFS_PPR_MIN && wdata_i <= `MPFS_PPR_MAX)
		|=> st_r.ppr == $past(wdata_i))
		else $error("pulse count not stored");
	chk_opt_store: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_i && addr_i == `MPFS_IDX_OPT)
		|=> st_r.opt == $past(wdata_i))
		else $error("option flags not stored");
	chk_sel_store: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_i && addr_i == `MPFS_IDX_SEL)
		|=> st_r.sel == $past(wdata_i))
		else $error("sensor select not stored");
	chk_motor_store: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_i && addr_i == `MPFS_IDX_MOTOR)
		|=> st_r.motor == $past(wdata_i))
		else $error("motor type not stored");
	chk_mask_store: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_i && addr_i == `MPFS_IDX_MASK)
		|=> st_r.mask == $past(wdata_i[2:0]))
		else $error("mask not stored");
	chk_badsel_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_i && addr_i == `MPFS_IDX_STATUS && wdata_i[`MPFS_ST_BADSEL])
		|=> !st_r.status[`MPFS_ST_BADSEL])
		else $error("invalid selector flag not cleared");
	// ----------------------------------------
	// checks: faults
	// ----------------------------------------
	chk_fault_code: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		fault_code_o == (power_cycle_required_marker_o
		? `MPFS_FAULT_PCF : 8'h00))
		else $error("fault code disagrees with marker");
	chk_ppr_same: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_i && addr_i == `MPFS_IDX_PPR && wdata_i == st_r.ppr && !st_r.power_cycle_required_marker)
		|=> !st_r.power_cycle_required_marker)
		else $error("unchanged pulse count raised fault");
	chk_opt_same: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_i && addr_i == `MPFS_IDX_OPT && !st_r.power_cycle_required_marker && wdata_i[0] == st_r.opt[0])
		|=> !st_r.power_cycle_required_marker)
		else $error("unchanged invert flag raised fault");
	chk_pcf_event: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(st_r.power_cycle_required_marker)
		|-> st_r.status[`MPFS_ST_PCF])
		else $error("parameter change event not recorded");
	chk_mis_event: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(st_r.mismatch)
		|-> st_r.status[`MPFS_ST_MISMATCH])
		else $error("mismatch event not recorded");
	chk_mis_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st_r.motor == `MPFS_MOTOR_IND && st_r.sel == `MPFS_SEL_QUAD)
		|=> !st_r.mismatch)
		else $error("mismatch on a matching pair");
	// ----------------------------------------
	// checks: position and count
	// ----------------------------------------
	chk_pos_down: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(step && !dir_up && sens == MPFS_SENS_QUAD && st_r.pos != 16'h0000 && !wr_i)
		|=> st_r.pos == $past(st_r.pos) - 16'h0001)
		else $error("position did not go back");
	chk_wrap_up: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(step && dir_up && sens == MPFS_SENS_QUAD && st_r.pos == st_r.ppr - 16'h0001)
		|=> st_r.pos == 16'h0000)
		else $error("position did not wrap to zero");
	chk_wrap_down: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(step && !dir_up && sens == MPFS_SENS_QUAD && st_r.pos == 16'h0000 && !wr_i)
		|=> st_r.pos == $past(st_r.ppr) - 16'h0001)
		else $error("position did not wrap to top");
	chk_count_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(step && sens == MPFS_SENS_QUAD)
		|=> st_r.count == $past(st_r.count) + ($past(dir_up) ? 16'h0001 : 16'hFFFF))
		else $error("count did not follow step");
	chk_count_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!(step && sens == MPFS_SENS_QUAD)
		|=> st_r.count == $past(st_r.count))
		else $error("count moved without a quadrature step");
endmodule

// *** test/mpfs_enc_model.sv ***
// behavioural quadrature encoder on the motor shaft
`timescale 1ns/1ps
module mpfs_enc_model
(
	input wire logic clk_i,
	input wire logic step_i,
	input wire logic fwd_i,
	output logic enc_a_o,
	output logic enc_b_o
);
	logic [1:0] ph_r = 2'h0;
	// gray phase: only one line moves per step, as on a real disc
	always_ff @(posedge clk_i)
	begin
		if (step_i)
			ph_r <= fwd_i ? ph_r + 2'h1 : ph_r - 2'h1;
	end
	assign enc_a_o = ph_r[1];
	assign enc_b_o = ph_r[1] ^ ph_r[0];
endmodule

// *** test/tb.sv ***
// self-checking bench for the motor position feedback setup block
`timescale 1ns/1ps
`include "mpfs_consts.svh"
module tb;
	localparam int SAMPLE_CYC = 16;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic step = 1'b0;
	logic fwd = 1'b1;
	logic enc_a, enc_b, irq_o, mismatch_o, pcf_o;
	logic [15:0] rdata_o, position_o, speed_o, rd_val, v, p;
	logic [7:0] fault_code_o;
	logic [31:0] seed = 32'h8062;
	logic [15:0] mt[6] = '{16'h0, 16'h0, 16'h1, 16'h1, 16'h0, 16'h1};
	logic [15:0] sl[6] = '{16'h1, 16'h2, 16'h2, 16'h1, 16'h3, 16'h0};
	logic mm[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
	int errors = 0;
	int checked = 0;
	int pos = 0;

	mpfs_top #(.SAMPLE_CYC(SAMPLE_CYC)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .enc_a_i(enc_a),
		.enc_b_i(enc_b), .rdata_o(rdata_o), .irq_o(irq_o), .mismatch_o(mismatch_o),
		.power_cycle_required_marker_o(pcf_o), .fault_code_o(fault_code_o),
		.position_o(position_o), .speed_o(speed_o));
	mpfs_enc_model u_enc (.clk_i(clk_i), .step_i(step), .fwd_i(fwd), .enc_a_o(enc_a),
		.enc_b_o(enc_b));

	initial
	begin
		forever #25 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [15:0] clamp(input logic [15:0] d);
		if (d < `MPFS_PPR_MIN)
			return `MPFS_PPR_MIN;
		return (d > `MPFS_PPR_MAX) ? `MPFS_PPR_MAX : d;
	endfunction
	function automatic logic [15:0] spd(input int d, input int n);
		return 16'(d * 256 / n);
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		if (errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic do_reset;
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		repeat (16) @(posedge clk_i);
		rst_b_i <= 1'b1;
		pos = 0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		check(rdata_o, exp);
	endtask
	task automatic settle;
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	// 4-cycle step period gives a steady count of 4 per speed sample
	task automatic steps(input int n, input logic up);
		repeat (n)
		begin
			@(posedge clk_i);
			step <= 1'b1;
			fwd <= up;
			@(posedge clk_i);
			step <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
		// look past the edge so outputs launched on it have settled
		#1;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial
	begin
		do_reset();
		rdchk(`MPFS_IDX_PPR, `MPFS_PPR_RST);
		rdchk(`MPFS_IDX_OPT, `MPFS_OPT_RST);
		rdchk(`MPFS_IDX_SEL, `MPFS_SEL_RST);
		rdchk(16'h3A00, 16'h0000);
		wr(`MPFS_IDX_OPT, 16'h0000);
		wr(`MPFS_IDX_PPR, `MPFS_PPR_RST);
		settle();
		check({15'h0, pcf_o}, 16'h0000);
		for (int i = 0; i < 40; i++)
		begin
			seed = xs(seed);
			steps(1, seed[0]);
			pos = (pos + (seed[0] ? 1 : -1) + 32) % 32;
		end
		settle();
		check(position_o, 16'(pos));
		for (int i = 0; i < 6; i++)
		begin
			wr(`MPFS_IDX_MOTOR, mt[i]);
			wr(`MPFS_IDX_SEL, sl[i]);
			settle();
			check({15'h0, mismatch_o}, {15'h0, mm[i]});
		end
		rdchk(`MPFS_IDX_STATUS, 16'h0005);
		check({15'h0, irq_o}, 16'h0000);
		wr(`MPFS_IDX_MASK, 16'h0004);
		settle();
		check({15'h0, irq_o}, 16'h0001);
		wr(`MPFS_IDX_STATUS, 16'h0004);
		settle();
		check({15'h0, irq_o}, 16'h0000);
		wr(`MPFS_IDX_MOTOR, `MPFS_MOTOR_IND);
		wr(`MPFS_IDX_SEL, `MPFS_SEL_SINCOS);
		steps(3, 1'b1);
		settle();
		check(position_o, 16'(pos));
		wr(`MPFS_IDX_SEL, `MPFS_SEL_QUAD);
		steps(12, 1'b1);
		check(speed_o, spd(4, 32));
		do_reset();
		seed = xs(seed);
		v = {7'h00, seed[8:0]};
		p = clamp(v);
		wr(`MPFS_IDX_PPR, v);
		rdchk(`MPFS_IDX_PPR, p);
		check({15'h0, pcf_o}, {15'h0, p != `MPFS_PPR_RST});
		steps(12, 1'b1);
		check(speed_o, spd(4, p));
		settle();
		check(position_o, 16'(12 % p));
		wr(`MPFS_IDX_PPR, `MPFS_PPR_MAX);
		rdchk(`MPFS_IDX_PPR, `MPFS_PPR_MAX);
		do_reset();
		check({15'h0, pcf_o}, 16'h0000);
		wr(`MPFS_IDX_MASK, 16'h0002);
		wr(`MPFS_IDX_OPT, 16'h0001);
		settle();
		check({8'h0, fault_code_o}, {8'h0, `MPFS_FAULT_PCF});
		check({15'h0, irq_o}, 16'h0001);
		rdchk(`MPFS_IDX_FAULT, 16'h8031);
		steps(12, 1'b1);
		check(speed_o, spd(-4, 32));
		settle();
		check(position_o, 16'h0014);
		wr(`MPFS_IDX_STATUS, 16'h0002);
		settle();
		check({15'h0, irq_o}, 16'h0000);
		check({15'h0, pcf_o}, 16'h0001);
		end_of_test();
	end

	initial
	begin
		#(50 * 5000);
		errors++;
		end_of_test();
	end
endmodule
